// ### rtl/scg_clkgen.v
// Purpose: Clock source selection, PLL output division and clock routing with APB control.
// Assumes: Every oscillator feeding a glitch-free selector keeps running while it is
// being switched away from or to.
// Notes: The analog PLL loop is outside; this block drives its multiplier and power-down.
`timescale 1ns/1ps
`include "scg_clkgen_regs.vh"

module scg_gfmux #(
   parameter N = 2,
   parameter SW = 1
) (
   // Clocks, select and reset
   input wire [N-1:0] clk_in,
   input wire [SW-1:0] sel,
   input wire rst_n,
   // Result
   output wire clk_out,
   output wire [N-1:0] active
);
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_src
         localparam [SW-1:0] IDX = i;
         wire [N-1:0] self_bit = {{(N-1){1'b0}}, 1'b1} << i;
         // A source may only start once every other enable has dropped.
         wire req = (sel == IDX) && ((active & ~self_bit) == {N{1'b0}});
         reg stage1_reg;
         reg stage2_reg;
         // Enables change on the falling edge, while the source is low, so the AND
         // below never cuts a high phase short.
         always @(negedge clk_in[i] or negedge rst_n) begin
            if (!rst_n) begin
               stage1_reg <= 1'b0;
               stage2_reg <= 1'b0;
            end else begin
               stage1_reg <= req;
               stage2_reg <= stage1_reg;
            end
         end
         assign active[i] = stage2_reg;
      end
   endgenerate
   assign clk_out = |(clk_in & active);
endmodule

module scg_clkgen (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`SCG_ADDR_W-1:0] paddr,
   input wire [`SCG_DATA_W-1:0] pwdata,
   output wire pready,
   output wire [`SCG_DATA_W-1:0] prdata,
   output wire pslverr,
   // Oscillators
   input wire internal_rc_osc,
   input wire crystal_osc,
   input wire external_clock_input,
   input wire watchdog_osc,
   input wire lowpower_osc,
   // PLL analog loop
   input wire pll_current_osc,
   input wire pll_lock,
   output wire [`SCG_MULT_W-1:0] pll_feedback_mult,
   output wire pll_power_down,
   output wire pll_ref_clk,
   // Routed clocks and the low-power oscillator enable
   output wire main_clk,
   output wire windowed_watchdog_clk,
   output wire wakeup_timer_clk,
   output wire lowpower_osc_enable,
   output wire clock_out_function
);
   reg [`SCG_SEL_W-1:0] main_sel_reg;
   reg [`SCG_SEL_W-1:0] pll_src_reg;
   reg [`SCG_MULT_W-1:0] mult_reg;
   reg [`SCG_DIV_W-1:0] div_reg;
   reg pll_en_reg;
   reg wdt_sel_reg;
   reg [`SCG_SEL_W-1:0] clock_out_function_sel_reg;
   reg lpo_en_reg;
   reg [`SCG_DATA_W-1:0] prdata_reg;
   reg pslverr_reg;
   reg [`SCG_DATA_W-1:0] rdata_next;
   reg lock_s1_reg;
   reg lock_s2_reg;
   reg [2:0] main_s1_reg;
   reg [2:0] main_s2_reg;
   reg [1:0] pact_s1_reg;
   reg [1:0] pact_s2_reg;
   reg en_cco_s1_reg;
   reg en_cco_s2_reg;
   reg [`SCG_DIV_CNT_W-1:0] div_cnt_reg;
   reg [`SCG_DIV_W-1:0] div_cco_reg;
   reg en_back_s1_reg;
   reg en_back_s2_reg;
   reg div_live_s1_reg;
   reg div_live_s2_reg;
   wire [2:0] main_active;
   wire [1:0] pll_active;
   wire pll_divided;
   wire pll_out;
   wire setup;
   wire wr_access;

   function is_mapped;
      input [`SCG_ADDR_W-1:0] a;
      begin
         case (a)
            `SCG_MAIN_SEL_OFS, `SCG_PLL_SRC_OFS, `SCG_PLL_CTRL_OFS, `SCG_PLL_STAT_OFS,
            `SCG_WDT_SEL_OFS, `SCG_CLOCK_OUT_FUNCTION_SEL_OFS, `SCG_LPO_CTRL_OFS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // The slave never stalls; read data and error are prepared in the setup cycle.
   assign pready = 1'b1;
   assign setup = psel && !penable;
   assign wr_access = psel && penable && pwrite && is_mapped(paddr);
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_sel_reg <= `SCG_MAIN_IRC;
         pll_src_reg <= `SCG_PLL_SRC_IRC;
         mult_reg <= `SCG_MULT_RST;
         div_reg <= `SCG_DIV_RST;
         pll_en_reg <= 1'b0;
         wdt_sel_reg <= `SCG_WDT_WATCHDOG_OSC;
         clock_out_function_sel_reg <= `SCG_CLOCK_OUT_FUNCTION_IRC;
         lpo_en_reg <= `SCG_LPO_EN_RST;
      end else if (wr_access) begin
         case (paddr)
            `SCG_MAIN_SEL_OFS: begin
               // The reserved code is ignored so the main clock can never be stopped.
               if (pwdata[`SCG_SEL_W-1:0] != `SCG_SEL_RSVD) begin
                  main_sel_reg <= pwdata[`SCG_SEL_W-1:0];
               end
            end
            `SCG_PLL_SRC_OFS: begin
               if (pwdata[`SCG_SEL_W-1:0] != `SCG_SEL_RSVD) begin
                  pll_src_reg <= pwdata[`SCG_SEL_W-1:0];
               end
            end
            `SCG_PLL_CTRL_OFS: begin
               mult_reg <= pwdata[`SCG_MULT_MSB:`SCG_MULT_LSB];
               div_reg <= pwdata[`SCG_DIV_MSB:`SCG_DIV_LSB];
               pll_en_reg <= pwdata[`SCG_PLL_EN_BIT];
            end
            `SCG_WDT_SEL_OFS: wdt_sel_reg <= pwdata[`SCG_WDT_SEL_BIT];
            `SCG_CLOCK_OUT_FUNCTION_SEL_OFS: clock_out_function_sel_reg <= pwdata[`SCG_SEL_W-1:0];
            `SCG_LPO_CTRL_OFS: lpo_en_reg <= pwdata[`SCG_LPO_EN_BIT];
            default: lpo_en_reg <= lpo_en_reg;
         endcase
      end
   end

   always @* begin
      rdata_next = {`SCG_DATA_W{1'b0}};
      case (paddr)
         `SCG_MAIN_SEL_OFS: rdata_next[`SCG_SEL_W-1:0] = main_sel_reg;
         `SCG_PLL_SRC_OFS: rdata_next[`SCG_SEL_W-1:0] = pll_src_reg;
         `SCG_PLL_CTRL_OFS: begin
            rdata_next[`SCG_MULT_MSB:`SCG_MULT_LSB] = mult_reg;
            rdata_next[`SCG_DIV_MSB:`SCG_DIV_LSB] = div_reg;
            rdata_next[`SCG_PLL_EN_BIT] = pll_en_reg;
         end
         `SCG_PLL_STAT_OFS: begin
            rdata_next[`SCG_STAT_LOCK_BIT] = lock_s2_reg;
            rdata_next[`SCG_STAT_ENSYNC_BIT] = en_back_s2_reg;
            rdata_next[`SCG_STAT_PLLACT_MSB:`SCG_STAT_PLLACT_LSB] = pact_s2_reg;
            rdata_next[`SCG_STAT_MAIN_MSB:`SCG_STAT_MAIN_LSB] = main_s2_reg;
         end
         `SCG_WDT_SEL_OFS: rdata_next[`SCG_WDT_SEL_BIT] = wdt_sel_reg;
         `SCG_CLOCK_OUT_FUNCTION_SEL_OFS: rdata_next[`SCG_SEL_W-1:0] = clock_out_function_sel_reg;
         `SCG_LPO_CTRL_OFS: rdata_next[`SCG_LPO_EN_BIT] = lpo_en_reg;
         default: rdata_next = {`SCG_DATA_W{1'b0}};
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= {`SCG_DATA_W{1'b0}};
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= pwrite ? {`SCG_DATA_W{1'b0}} : rdata_next;
         pslverr_reg <= !is_mapped(paddr);
      end
   end

   // Status from other clock domains is brought in through two-stage synchronisers.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_s1_reg <= 1'b0;
         lock_s2_reg <= 1'b0;
         main_s1_reg <= 3'h0;
         main_s2_reg <= 3'h0;
         pact_s1_reg <= 2'h0;
         pact_s2_reg <= 2'h0;
         en_back_s1_reg <= 1'b0;
         en_back_s2_reg <= 1'b0;
      end else begin
         lock_s1_reg <= pll_lock;
         lock_s2_reg <= lock_s1_reg;
         main_s1_reg <= main_active;
         main_s2_reg <= main_s1_reg;
         pact_s1_reg <= pll_active;
         pact_s2_reg <= pact_s1_reg;
         en_back_s1_reg <= en_cco_s2_reg;
         en_back_s2_reg <= en_back_s1_reg;
      end
   end

   // The multiplier code is M-1, so codes 0 to 31 give factors 1 to 32.
   assign pll_feedback_mult = mult_reg;
   assign pll_power_down = !pll_en_reg;

   scg_gfmux #(.N(3), .SW(`SCG_SEL_W)) u_pll_src (
      .clk_in({external_clock_input, crystal_osc, internal_rc_osc}),
      .sel(pll_src_reg),
      .rst_n(presetn),
      .clk_out(pll_ref_clk),
      .active()
   );

   // Output divider on the oscillator of the loop. The divide ratio is taken over only
   // while the PLL is off and the bypass switch has let go of the divided clock, so a
   // live reprogram cannot produce a short phase. The counter runs on until then,
   // because the switch needs falling edges of the clock it leaves; otherwise a main
   // clock running from the PLL would stop for good when the PLL is disabled. The loop
   // oscillator must therefore toggle for a few edges after the enable drops.
   always @(posedge pll_current_osc or negedge presetn) begin
      if (!presetn) begin
         en_cco_s1_reg <= 1'b0;
         en_cco_s2_reg <= 1'b0;
         div_live_s1_reg <= 1'b0;
         div_live_s2_reg <= 1'b0;
         div_cnt_reg <= {`SCG_DIV_CNT_W{1'b0}};
         div_cco_reg <= `SCG_DIV_RST;
      end else begin
         en_cco_s1_reg <= pll_en_reg;
         en_cco_s2_reg <= en_cco_s1_reg;
         div_live_s1_reg <= pll_active[`SCG_BYP_DIV_IDX];
         div_live_s2_reg <= div_live_s1_reg;
         if (!en_cco_s2_reg && !div_live_s2_reg) begin
            div_cnt_reg <= {`SCG_DIV_CNT_W{1'b0}};
            div_cco_reg <= div_reg;
         end else begin
            div_cnt_reg <= div_cnt_reg + {{(`SCG_DIV_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Counter bit k is a flop output toggling every 2^k edges: divide by 2^(k+1), even duty.
   assign pll_divided = div_cnt_reg[div_cco_reg];

   // Bypass is itself a glitch-free switch between the reference and the divided clock.
   scg_gfmux #(.N(2), .SW(1)) u_pll_bypass (
      .clk_in({pll_divided, pll_ref_clk}),
      .sel(en_cco_s2_reg ? 1'b1 : 1'b0),
      .rst_n(presetn),
      .clk_out(pll_out),
      .active(pll_active)
   );

   scg_gfmux #(.N(3), .SW(`SCG_SEL_W)) u_main (
      .clk_in({pll_out, crystal_osc, internal_rc_osc}),
      .sel(main_sel_reg),
      .rst_n(presetn),
      .clk_out(main_clk),
      .active(main_active)
   );

   scg_gfmux #(.N(2), .SW(1)) u_wdt (
      .clk_in({internal_rc_osc, watchdog_osc}),
      .sel(wdt_sel_reg),
      .rst_n(presetn),
      .clk_out(windowed_watchdog_clk),
      .active()
   );

   scg_gfmux #(.N(4), .SW(`SCG_SEL_W)) u_clock_out_function (
      .clk_in({main_clk, watchdog_osc, crystal_osc, internal_rc_osc}),
      .sel(clock_out_function_sel_reg),
      .rst_n(presetn),
      .clk_out(clock_out_function),
      .active()
   );

   // The wake-up timer clock is not gated here so no power mode of this block stops it.
   assign wakeup_timer_clk = lowpower_osc;
   assign lowpower_osc_enable = lpo_en_reg;
endmodule

// ### rtl/scg_clkgen_regs.vh
// Purpose: Constants for the system clock generation block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
`ifndef SCG_CLKGEN_REGS_VH
`define SCG_CLKGEN_REGS_VH

`define SCG_ADDR_W 12
`define SCG_DATA_W 32

// Register byte offsets.
`define SCG_MAIN_SEL_OFS 12'h000
`define SCG_PLL_SRC_OFS 12'h004
`define SCG_PLL_CTRL_OFS 12'h008
`define SCG_PLL_STAT_OFS 12'h00C
`define SCG_WDT_SEL_OFS 12'h010
`define SCG_CLOCK_OUT_FUNCTION_SEL_OFS 12'h014
`define SCG_LPO_CTRL_OFS 12'h018

// Selector codes.
`define SCG_SEL_W 2
`define SCG_SEL_RSVD 2'h3
`define SCG_MAIN_IRC 2'h0
`define SCG_PLL_SRC_IRC 2'h0
`define SCG_CLOCK_OUT_FUNCTION_IRC 2'h0
`define SCG_WDT_WATCHDOG_OSC 1'h0
`define SCG_WDT_SEL_BIT 0

// PLL control fields.
`define SCG_MULT_W 5
`define SCG_MULT_LSB 0
`define SCG_MULT_MSB 4
`define SCG_DIV_W 2
`define SCG_DIV_LSB 5
`define SCG_DIV_MSB 6
`define SCG_PLL_EN_BIT 8
`define SCG_MULT_RST 5'h00
`define SCG_DIV_RST 2'h0
`define SCG_DIV_CNT_W 4
// Position of the divided clock in the bypass switch.
`define SCG_BYP_DIV_IDX 1

// Status fields.
`define SCG_STAT_LOCK_BIT 0
`define SCG_STAT_ENSYNC_BIT 1
`define SCG_STAT_PLLACT_LSB 2
`define SCG_STAT_PLLACT_MSB 3
`define SCG_STAT_MAIN_LSB 4
`define SCG_STAT_MAIN_MSB 6
`define SCG_LPO_EN_BIT 0
`define SCG_LPO_EN_RST 1'h1

`endif

// ### dv/scg_clkgen_properties.sv
// Purpose: Port-level checks for the clock generation block.
// Assumes: Oscillators toggle in step with pclk, so sampled clock levels are meaningful.
// Notes: Watchdog clock checks wait 31 cycles after a select write to let the mux settle.
`timescale 1ns/1ps
`include "scg_clkgen_regs.vh"
module scg_clkgen_properties (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`SCG_ADDR_W-1:0] paddr,
   input wire [`SCG_DATA_W-1:0] pwdata,
   // Clocks and controls
   input wire internal_rc_osc,
   input wire watchdog_osc,
   input wire lowpower_osc,
   input wire main_clk,
   input wire windowed_watchdog_clk,
   input wire wakeup_timer_clk,
   input wire lowpower_osc_enable,
   input wire pll_power_down,
   input wire [`SCG_MULT_W-1:0] pll_feedback_mult
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr = psel && penable && pwrite;
   wire ctl_wr = wr && (paddr == `SCG_PLL_CTRL_OFS);
   reg moved_reg;
   reg wsel_reg;
   reg [4:0] wage_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         moved_reg <= 1'h0;
         wsel_reg <= 1'h0;
         wage_reg <= 5'h00;
      end else begin
         if (wr && paddr == `SCG_MAIN_SEL_OFS && (pwdata[1:0] == 2'h1 || pwdata[1:0] == 2'h2))
            moved_reg <= 1'h1;
         if (wr && paddr == `SCG_WDT_SEL_OFS) begin
            wsel_reg <= pwdata[0];
            wage_reg <= 5'h00;
         end else if (wage_reg != 5'h1F)
            wage_reg <= wage_reg + 5'h01;
      end
   end
   property p_rst_main;
      !moved_reg |-> (!main_clk || internal_rc_osc);
   endproperty
   a_rst_main: assert property (p_rst_main) else $error("main clock not from RC");
   property p_pd_hold;
      pll_power_down && !(ctl_wr && pwdata[`SCG_PLL_EN_BIT]) |=> pll_power_down;
   endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("PLL powered up unasked");
   property p_pd_en;
      ctl_wr |=> pll_power_down == !$past(pwdata[`SCG_PLL_EN_BIT]);
   endproperty
   a_pd_en: assert property (p_pd_en) else $error("PLL power-down wrong");
   property p_mult;
      ctl_wr |=> pll_feedback_mult == $past(pwdata[4:0]);
   endproperty
   a_mult: assert property (p_mult) else $error("multiplier wrong");
   property p_wkt;
      wakeup_timer_clk == lowpower_osc;
   endproperty
   a_wkt: assert property (p_wkt) else $error("wake-up clock wrong");
   property p_lpo;
      wr && paddr == `SCG_LPO_CTRL_OFS |=> lowpower_osc_enable == $past(pwdata[0]);
   endproperty
   a_lpo: assert property (p_lpo) else $error("low-power enable wrong");
   property p_wdt_osc;
      wage_reg == 5'h1F && !wsel_reg |-> windowed_watchdog_clk == watchdog_osc;
   endproperty
   a_wdt_osc: assert property (p_wdt_osc) else $error("watchdog clock wrong");
   property p_wdt_irc;
      wage_reg == 5'h1F && wsel_reg |-> windowed_watchdog_clk == internal_rc_osc;
   endproperty
   a_wdt_irc: assert property (p_wdt_irc) else $error("watchdog RC clock wrong");
   c_pll_on: cover property (ctl_wr && pwdata[`SCG_PLL_EN_BIT]);
   c_main_move: cover property ($rose(moved_reg));
   c_wdt_irc: cover property (wage_reg == 5'h1F && wsel_reg);
endmodule
bind scg_clkgen scg_clkgen_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .internal_rc_osc, .watchdog_osc, .lowpower_osc, .main_clk,
   .windowed_watchdog_clk, .wakeup_timer_clk, .lowpower_osc_enable, .pll_power_down,
   .pll_feedback_mult);

// ### dv/scg_clkgen_tb_top.sv
// Purpose: Self-checking bench for the clock generation block.
// Assumes: Oscillators are pclk-derived toggles of distinct periods, except the RC and loop oscillators, which share one.
// Notes: Clocks are sampled on the falling pclk edge, where every path has settled.
`timescale 1ns/1ps
`include "scg_clkgen_regs.vh"
module scg_clkgen_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pll_lock = 0;
   logic internal_rc_osc = 0, crystal_osc = 0, external_clock_input = 0;
   logic watchdog_osc = 0, lowpower_osc = 0, pll_current_osc = 0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, rd;
   logic [7:0] cnt = 8'h00;
   logic [4:0] m;
   wire pready, pslverr, pll_power_down, main_clk, windowed_watchdog_clk;
   wire wakeup_timer_clk, lowpower_osc_enable, clock_out_function, pll_ref_clk;
   wire [31:0] prdata;
   wire [4:0] pll_feedback_mult;
   int miscompares = 0, checked = 0, t, h;
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cnt <= cnt + 8'h01;
      internal_rc_osc <= ~internal_rc_osc;
      pll_current_osc <= ~pll_current_osc;
      crystal_osc <= cnt[1];
      external_clock_input <= cnt[3];
      watchdog_osc <= cnt[2];
      lowpower_osc <= cnt[4];
   end
   scg_clkgen DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .internal_rc_osc, .crystal_osc, .external_clock_input,
      .watchdog_osc, .lowpower_osc, .pll_current_osc, .pll_lock, .pll_feedback_mult,
      .pll_power_down, .pll_ref_clk, .main_clk, .windowed_watchdog_clk,
      .wakeup_timer_clk, .lowpower_osc_enable, .clock_out_function);
   task automatic tally_and_finish;
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Returning on the falling edge lets a write settle before the caller looks.
      @(negedge pclk);
   endtask
   function automatic logic src(input int s);
      case (s)
         0: src = internal_rc_osc;
         1: src = crystal_osc;
         2: src = watchdog_osc;
         4: src = external_clock_input;
         default: src = main_clk;
      endcase
   endfunction
   // The wait covers dropping the old source and two falling edges of the slowest new one.
   task automatic ckc(input int o, input int s);
      logic g;
      repeat (120) @(posedge pclk);
      repeat (16) begin
         @(negedge pclk);
         g = (o == 0) ? main_clk : (o == 1) ? clock_out_function :
            (o == 2) ? windowed_watchdog_clk : pll_ref_clk;
         ck({31'h0, g}, {31'h0, src(s)});
      end
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(42));
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      ckc(0, 0);
      ap(1'h0, `SCG_PLL_STAT_OFS, 32'h0);
      ck(rd, 32'h14);
      ap(1'h0, `SCG_MAIN_SEL_OFS, 32'h0);
      ck(rd, 32'h0);
      ap(1'h0, `SCG_PLL_CTRL_OFS, 32'h0);
      ck({rd[31:1], pll_power_down}, 32'h1);
      ap(1'h0, `SCG_LPO_CTRL_OFS, 32'h0);
      ck(rd, 32'h1);
      ap(1'h0, 12'h01C, 32'h0);
      ck({31'h0, er}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         m = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom_range(31, 0));
         ap(1'h1, `SCG_PLL_CTRL_OFS, {27'h0, m});
         ck({27'h0, pll_feedback_mult}, {27'h0, m});
         ck({31'h0, pll_power_down}, 32'h1);
      end
      ap(1'h1, `SCG_MAIN_SEL_OFS, 32'h1);
      ckc(0, 1);
      ap(1'h1, `SCG_MAIN_SEL_OFS, 32'h3);
      ap(1'h0, `SCG_MAIN_SEL_OFS, 32'h0);
      ck(rd, 32'h1);
      ap(1'h1, `SCG_MAIN_SEL_OFS, 32'h0);
      ckc(0, 0);
      ap(1'h1, `SCG_PLL_SRC_OFS, 32'h1);
      ap(1'h1, `SCG_MAIN_SEL_OFS, 32'h2);
      ckc(0, 1);
      ckc(3, 1);
      ap(1'h1, `SCG_PLL_SRC_OFS, 32'h2);
      ap(1'h1, `SCG_PLL_SRC_OFS, 32'h3);
      ap(1'h0, `SCG_PLL_SRC_OFS, 32'h0);
      ck(rd, 32'h2);
      ckc(3, 4);
      ckc(0, 4);
      ap(1'h1, `SCG_PLL_SRC_OFS, 32'h0);
      pll_lock <= 1'h1;
      for (int d = 0; d < 4; d++) begin
         ap(1'h1, `SCG_PLL_CTRL_OFS, {25'h0, d[1:0], 5'h00});
         // The bypass switch must leave the divided clock before a new ratio is taken.
         repeat (60) @(posedge pclk);
         ap(1'h1, `SCG_PLL_CTRL_OFS, {23'h0, 1'h1, 1'h0, d[1:0], 5'h00});
         repeat (150) @(posedge pclk);
         @(negedge pclk);
         t = 0;
         h = 0;
         er = main_clk;
         repeat (64) begin
            @(negedge pclk);
            t += (main_clk !== er);
            h += (main_clk === 1'h1);
            er = main_clk;
         end
         ck(t, 32 >> d);
         ck(h, 32);
      end
      ap(1'h0, `SCG_PLL_STAT_OFS, 32'h0);
      ck(rd, 32'h4B);
      for (int s = 0; s < 4; s++) begin
         ap(1'h1, `SCG_CLOCK_OUT_FUNCTION_SEL_OFS, s);
         ckc(1, s);
      end
      ap(1'h1, `SCG_WDT_SEL_OFS, 32'h1);
      ckc(2, 0);
      ap(1'h1, `SCG_WDT_SEL_OFS, 32'h0);
      ckc(2, 2);
      ap(1'h1, `SCG_LPO_CTRL_OFS, 32'h0);
      ck({31'h0, lowpower_osc_enable}, 32'h0);
      ap(1'h1, `SCG_LPO_CTRL_OFS, 32'h1);
      ck({31'h0, lowpower_osc_enable}, 32'h1);
      tally_and_finish();
   end
endmodule
